// ==== rtl/pcp_pkg.sv ====
// =====================================================================
// shared constants and types for the card host port
// =====================================================================
package pcp_pkg;

   // bus widths
   localparam int ADDR_W = 21;
   localparam int DATA_W = 16;
   localparam int STRAP_W = 16;
   localparam int BUF_ADDR_W = 20; // word address of a 2M byte buffer

   // register space: 47 bytes, repeating every 64 bytes
   localparam int REG_BYTES = 47;
   localparam int REG_ALIAS_W = 6;
   localparam logic [REG_ALIAS_W-1:0] REG_COUNT = 6'h2f;
   localparam logic [REG_ALIAS_W-1:0] REG_ID_IDX = 6'h00;
   localparam logic [REG_ALIAS_W-1:0] REG_MISC_IDX = 6'h01;
   localparam logic [REG_ALIAS_W-2:0] REG_OPEN_WORD = 5'h00;
   localparam int MISC_LOCK_BIT = 7;
   localparam logic [7:0] MISC_RESET = 8'h80;
   localparam logic [7:0] REG_CLEAR = 8'h00;

   // strap field positions
   localparam int STRAP_IFACE_LO = 1;
   localparam int STRAP_ENDIAN = 4;
   localparam int STRAP_WAIT_POL = 5;
   localparam int STRAP_VARIANT = 11;
   localparam int STRAP_HALVE = 12;
   localparam int STRAP_DRIVE = 15;
   localparam logic [2:0] IFACE_PC_CARD = 3'h7;

   // the port clock may not exceed this rate
   localparam int BUS_CLK_MAX_MHZ = 50;
   localparam int CLK_MHZ = 25;

   typedef struct packed {
      logic variant;       // 1 = alternate host interface
      logic halve;         // 1 = port clock divided by two
      logic drive_always;  // 1 = hold-off pin driven at all times
      logic wait_high;     // 1 = hold-off active high
      logic little;        // 1 = little endian
      logic [2:0] iface;   // interface select field
   } pcp_cfg_s;

   typedef struct packed {
      logic cs_n;
      logic mem_sel;
      logic hbe_n;
      logic lbe_n;
      logic rd_n;
      logic wr_n;
   } pcp_ctl_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MEM = 2'b01,
      ST_DONE = 2'b10
   } pcp_state_e;

endpackage : pcp_pkg

// ==== rtl/pcp_sync.sv ====
`timescale 1ns/10ps
// =====================================================================
// three stage pin synchroniser with agreement filter
// =====================================================================
module pcp_sync #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_q;
   logic [W-1:0] agree;

   // per bit: the change only counts once stages two and three agree
   assign agree = ~(s2_q ^ s3_q);
   assign sync_out = out_q;

   // no reset: pins settle within four edges, reset must be held longer
   always_ff @(posedge clk) begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= (agree & s3_q) | (~agree & out_q);
   end

endmodule : pcp_sync

// ==== rtl/pcp_host_port.sv ====
`timescale 1ns/10ps
module pcp_host_port
   import pcp_pkg::*;
#(
   parameter logic [7:0] ID_CODE = 8'h5a, // arbitrary identification value
   parameter int NUM_REGS = REG_BYTES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [pcp_pkg::STRAP_W-1:0] config_strap_in,
   input wire logic [pcp_pkg::ADDR_W-1:0] host_address_in,
   input wire logic [pcp_pkg::DATA_W-1:0] host_data_in,
   output logic [pcp_pkg::DATA_W-1:0] host_data_out,
   output logic host_data_oe,
   input wire logic chip_select_n,
   input wire logic mem_reg_select,
   input wire logic high_byte_enable_n,
   input wire logic low_byte_enable_n,
   input wire logic read_strobe_n,
   input wire logic low_write_strobe_n,
   input wire logic bus_start_n,
   output logic hold_off_out,
   output logic hold_off_oe,
   output logic buf_req,
   output logic buf_write,
   output logic [pcp_pkg::BUF_ADDR_W-1:0] buf_addr,
   output logic [pcp_pkg::DATA_W-1:0] buf_wdata,
   output logic [1:0] buf_byte_en,
   input wire logic buf_ack,
   input wire logic [pcp_pkg::DATA_W-1:0] buf_rdata,
   output pcp_pkg::pcp_cfg_s cfg_out,
   output logic regs_locked
);
   import pcp_pkg::*;

   // =================================================================
   // elaboration checks
   // =================================================================
   if (NUM_REGS < 2 || NUM_REGS > REG_BYTES) begin : g_bad_regs
      $error("register count out of range");
   end

   localparam int SYNC_W = 6 + ADDR_W + DATA_W + STRAP_W;

   // =================================================================
   // helpers
   // =================================================================
   // byte index of a bus lane; big endian swaps the lanes
   function automatic logic [REG_ALIAS_W-1:0] lane_idx(
      input logic [REG_ALIAS_W-2:0] word,
      input logic lane,
      input logic little
   );
      lane_idx = {word, lane ^ ~little};
   endfunction : lane_idx

   // swap the two bytes of a word in big endian mode
   function automatic logic [DATA_W-1:0] order_word(
      input logic [DATA_W-1:0] w,
      input logic little
   );
      order_word = little ? w : {w[7:0], w[15:8]};
   endfunction : order_word

   // =================================================================
   // pin synchronisers
   // =================================================================
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_sync;
   pcp_ctl_s ctl;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] wdata_s;
   logic [STRAP_W-1:0] strap_s;

   // all strobes pass three stages before decode
   assign pins_raw = {chip_select_n, mem_reg_select, high_byte_enable_n,
                      low_byte_enable_n, read_strobe_n, low_write_strobe_n,
                      host_address_in, host_data_in, config_strap_in};

   pcp_sync #(
      .W(SYNC_W)
   ) u_sync (
      .clk(clk),
      .async_in(pins_raw),
      .sync_out(pins_sync)
   );

   assign ctl = pins_sync[SYNC_W-1 -: 6];
   assign addr_s = pins_sync[DATA_W+STRAP_W +: ADDR_W];
   assign wdata_s = pins_sync[STRAP_W +: DATA_W];
   assign strap_s = pins_sync[STRAP_W-1:0];

   // =================================================================
   // strap capture
   // =================================================================
   pcp_cfg_s cfg_q;
   pcp_cfg_s strap_cfg;

   assign strap_cfg = '{variant: strap_s[STRAP_VARIANT],
                        halve: strap_s[STRAP_HALVE],
                        drive_always: strap_s[STRAP_DRIVE],
                        wait_high: strap_s[STRAP_WAIT_POL],
                        little: strap_s[STRAP_ENDIAN],
                        iface: strap_s[STRAP_IFACE_LO +: 3]};

   // tracks the pins while reset is held, frozen at its release
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_q <= strap_cfg;
      end
   end

   // =================================================================
   // clock halving tick
   // =================================================================
   logic tick_q;
   logic adv;

   // halved mode lets the sequencer leave idle on every other edge only
   assign adv = ~cfg_q.halve | tick_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= ~tick_q;
      end
   end

   // =================================================================
   // access decode
   // =================================================================
   logic port_en;
   logic [1:0] lanes;
   logic sel;
   logic rd_req;
   logic wr_req;
   logic any_req;
   logic is_mem;
   logic [REG_ALIAS_W-2:0] reg_word;
   logic [REG_ALIAS_W-1:0] idx0;
   logic [REG_ALIAS_W-1:0] idx1;
   logic locked;
   logic blocked;

   // only the card interface code opens the port; bus_start_n unused
   assign port_en = (cfg_q.iface == IFACE_PC_CARD);
   assign lanes = {~ctl.hbe_n, ~ctl.lbe_n};
   assign sel = ~ctl.cs_n & (|lanes) & port_en;
   assign rd_req = sel & ~ctl.rd_n;
   assign wr_req = sel & ~ctl.wr_n & ctl.rd_n;
   assign any_req = rd_req | wr_req;
   assign is_mem = ctl.mem_sel;
   // bit 0 ignored, bits above the alias window ignored
   assign reg_word = addr_s[REG_ALIAS_W-1:1];
   assign idx0 = lane_idx(reg_word, 1'b0, cfg_q.little);
   assign idx1 = lane_idx(reg_word, 1'b1, cfg_q.little);

   // =================================================================
   // register file
   // =================================================================
   logic [7:0] reg_q [1:NUM_REGS-1];
   logic [DATA_W-1:0] reg_rdata;
   logic reg_we;

   assign locked = reg_q[REG_MISC_IDX][MISC_LOCK_BIT];
   // while locked only the first word (registers 0 and 1) answers
   assign blocked = locked & (is_mem | (reg_word != REG_OPEN_WORD));

   function automatic logic [7:0] reg_byte(input logic [REG_ALIAS_W-1:0] i);
      logic [7:0] v;
      v = REG_CLEAR;
      if (i == REG_ID_IDX) begin
         v = ID_CODE; // read-only identity
      end else if (i < REG_ALIAS_W'(NUM_REGS)) begin
         v = reg_q[i];
      end
      reg_byte = v;
   endfunction : reg_byte

   // a process, not an assign: the function reads reg_q, which must wake it
   always_comb begin
      reg_rdata = {reg_byte(idx1), reg_byte(idx0)};
   end

   pcp_state_e state_q;
   pcp_state_e state_d;

   assign reg_we = (state_q == ST_IDLE) & adv & wr_req & ~is_mem & ~blocked;

   // each enabled lane writes its own byte; register 0 never changes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 1; i < NUM_REGS; i++) begin
            reg_q[i] <= (i == int'(REG_MISC_IDX)) ? MISC_RESET : REG_CLEAR;
         end
      end else if (reg_we) begin
         for (int i = 1; i < NUM_REGS; i++) begin
            if (lanes[0] && idx0 == REG_ALIAS_W'(i)) begin
               reg_q[i] <= wdata_s[7:0];
            end
            if (lanes[1] && idx1 == REG_ALIAS_W'(i)) begin
               reg_q[i] <= wdata_s[15:8];
            end
         end
      end
   end

   // =================================================================
   // access sequencer
   // =================================================================
   logic busy_d;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (adv && any_req) begin
               state_d = (is_mem && !blocked) ? ST_MEM : ST_DONE;
            end
         end
         ST_MEM: begin
            if (buf_ack) begin
               state_d = ST_DONE; // buffer arbitration finished
            end
         end
         ST_DONE: begin
            if (!any_req) begin
               state_d = ST_IDLE; // host ended the cycle
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // hold the host while a request waits or the buffer is busy
   assign busy_d = (state_d == ST_MEM) | ((state_d == ST_IDLE) & any_req);

   // =================================================================
   // output and data registers
   // =================================================================
   logic [DATA_W-1:0] rdata_q;
   logic data_oe_q;
   logic hold_q;
   logic hold_oe_q;
   logic req_q;
   logic write_q;
   logic [BUF_ADDR_W-1:0] baddr_q;
   logic [DATA_W-1:0] bwdata_q;
   logic [1:0] bbe_q;
   logic mem_start;

   assign mem_start = (state_q == ST_IDLE) & (state_d == ST_MEM);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         rdata_q <= '0;
         data_oe_q <= 1'b0;
         hold_q <= 1'b0;
         hold_oe_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_q == ST_IDLE && state_d == ST_DONE) begin
            rdata_q <= blocked ? '0 : reg_rdata;
         end else if (state_q == ST_MEM && buf_ack) begin
            rdata_q <= order_word(buf_rdata, cfg_q.little);
         end
         data_oe_q <= (state_d == ST_DONE) & rd_req;
         hold_q <= cfg_q.wait_high ? busy_d : ~busy_d;
         hold_oe_q <= cfg_q.drive_always | ~ctl.cs_n;
      end
   end

   // display buffer request: word address of the 2M byte buffer
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         req_q <= 1'b0;
         write_q <= 1'b0;
         baddr_q <= '0;
         bwdata_q <= '0;
         bbe_q <= '0;
      end else if (mem_start) begin
         req_q <= 1'b1;
         write_q <= wr_req;
         baddr_q <= addr_s[ADDR_W-1:1];
         bwdata_q <= order_word(wdata_s, cfg_q.little);
         bbe_q <= cfg_q.little ? lanes : {lanes[0], lanes[1]};
      end else if (state_q == ST_MEM && buf_ack) begin
         req_q <= 1'b0;
      end
   end

   assign host_data_out = rdata_q;
   assign host_data_oe = data_oe_q;
   assign hold_off_out = hold_q;
   assign hold_off_oe = hold_oe_q;
   assign buf_req = req_q;
   assign buf_write = write_q;
   assign buf_addr = baddr_q;
   assign buf_wdata = bwdata_q;
   assign buf_byte_en = bbe_q;
   assign cfg_out = cfg_q; // variant reported for the system
   assign regs_locked = reg_q[REG_MISC_IDX][MISC_LOCK_BIT];

endmodule : pcp_host_port

// ==== verif/pcp_host_port_monitor.sv ====
`timescale 1ns/10ps
// =====================================================================
// port checker for the card host port
// =====================================================================
module pcp_host_port_monitor
   import pcp_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic host_data_oe,
   input wire logic hold_off_out,
   input wire logic hold_off_oe,
   input wire logic buf_req,
   input wire logic buf_ack,
   input wire logic regs_locked,
   input wire logic [pcp_pkg::BUF_ADDR_W-1:0] buf_addr,
   input wire pcp_pkg::pcp_cfg_s cfg_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // buffer request must hold its address until taken
   a_buf_req_held: assert property (buf_req && !buf_ack |=> buf_req && $stable(buf_addr))
      else $error("buffer request dropped early");
   a_buf_req_drop: assert property (buf_req && buf_ack |=> !buf_req)
      else $error("buffer request kept after ack");
   // host is held off while the buffer answer is pending
   a_wait_on_buf: assert property (buf_req && $past(buf_req) |-> hold_off_out == cfg_out.wait_high)
      else $error("hold-off not asserted during buffer wait");
   a_read_released: assert property ($rose(host_data_oe) |-> hold_off_out != cfg_out.wait_high)
      else $error("read data driven while still holding off");
   // a foreign interface select keeps the port dead
   a_no_iface: assert property (cfg_out.iface != IFACE_PC_CARD |-> !host_data_oe && !buf_req)
      else $error("port answered with wrong interface select");
   a_lock_buf: assert property (regs_locked |-> !buf_req)
      else $error("buffer reached while registers locked");
   // two settle edges after release before the drive strap counts
   a_drive_oe: assert property (cfg_out.drive_always && !$past(sys_rst, 2) |-> hold_off_oe)
      else $error("hold-off pin floated with drive strap set");
   a_lock_reset: assert property ($fell(sys_rst) |-> regs_locked && !host_data_oe && !buf_req)
      else $error("port not quiet and locked after reset");
   a_idle_wait: assert property ($fell(sys_rst) |=> hold_off_out != cfg_out.wait_high)
      else $error("hold-off not idle after reset");
endmodule : pcp_host_port_monitor

bind pcp_host_port pcp_host_port_monitor pcp_host_port_monitor_i (.clk(clk), .sys_rst(sys_rst),
   .host_data_oe(host_data_oe), .hold_off_out(hold_off_out), .hold_off_oe(hold_off_oe),
   .buf_req(buf_req), .buf_ack(buf_ack), .regs_locked(regs_locked), .buf_addr(buf_addr),
   .cfg_out(cfg_out));

// ==== verif/pcp_card_host_model.sv ====
`timescale 1ns/10ps
// =====================================================================
// card socket controller model: drives strobes, honours hold-off
// =====================================================================
module pcp_card_host_model
   import pcp_pkg::*;
(
   input wire logic clk,
   input wire logic wait_high,
   input wire logic hold_off_out,
   input wire logic hold_off_oe,
   input wire logic host_data_oe,
   input wire logic [pcp_pkg::DATA_W-1:0] host_data_out,
   output logic [pcp_pkg::ADDR_W-1:0] host_address_in,
   output logic [pcp_pkg::DATA_W-1:0] host_data_in,
   output logic chip_select_n,
   output logic mem_reg_select,
   output logic high_byte_enable_n,
   output logic low_byte_enable_n,
   output logic read_strobe_n,
   output logic low_write_strobe_n,
   output logic bus_start_n
);
   logic wait_line;
   // pull-up on the wait line when nobody drives it
   assign wait_line = hold_off_oe ? hold_off_out : 1'b1;

   // chip select grounded, bus start tied high as on a real card slot
   initial begin
      chip_select_n = 1'b0;
      bus_start_n = 1'b1;
      {read_strobe_n, low_write_strobe_n, high_byte_enable_n, low_byte_enable_n} = 4'hf;
      host_address_in = '0;
      mem_reg_select = 1'b0;
      host_data_in = 16'h0000;
   end

   // one whole access; waits out hold-off for a bounded time, ok low if it never ends
   task automatic xfer(input logic rd, input logic msel, input logic [20:0] a,
         input logic [1:0] be_n, input logic [15:0] wd, output logic [15:0] rdata,
         output logic ok);
      int n;
      @(negedge clk);
      host_address_in = a;
      mem_reg_select = msel;
      host_data_in = rd ? ~host_data_in : wd; // released bus shows no stale value
      {high_byte_enable_n, low_byte_enable_n} = be_n;
      read_strobe_n = !rd;
      low_write_strobe_n = rd;
      repeat (8) @(posedge clk);
      n = 0;
      while (n < 60 && (wait_line === wait_high || (rd && host_data_oe !== 1'b1))) begin
         @(posedge clk);
         n++;
      end
      ok = (n < 60);
      rdata = host_data_out;
      @(negedge clk);
      {read_strobe_n, low_write_strobe_n, high_byte_enable_n, low_byte_enable_n} = 4'hf;
      host_data_in = ~host_data_in;
      repeat (10) @(negedge clk); // hand back off the sampling edge
   endtask : xfer
endmodule : pcp_card_host_model

// ==== verif/pcp_host_port_tb.sv ====
`timescale 1ns/10ps
// =====================================================================
// self-checking bench for the card host port
// =====================================================================
module pcp_host_port_tb;
   import pcp_pkg::*;
   localparam logic [7:0] ID = 8'h5a; // arbitrary identification value
   logic clk = 1'b0, sys_rst = 1'b1, wh = 1'b0, buf_ack = 1'b0, hold_off_out, hold_off_oe;
   logic host_data_oe, buf_req, buf_write, regs_locked, cs_n, msel, hbe_n, lbe_n, rd_n, wr_n;
   logic bs_n, ok;
   logic [15:0] strap = 16'h001e, buf_rdata = 16'h0000, host_data_out, host_data_in, buf_wdata;
   logic [15:0] d;
   logic [20:0] addr;
   logic [19:0] buf_addr, last_addr;
   logic [1:0] buf_byte_en;
   logic [15:0] bmem [0:15];
   pcp_cfg_s cfg_out;
   int errors = 0, samples_checked = 0, cyc = 0, stall = 0;

   always #20 clk = ~clk;

   pcp_host_port #(.ID_CODE(ID)) pcp_host_port_i (.clk(clk), .sys_rst(sys_rst),
      .config_strap_in(strap), .host_address_in(addr), .host_data_in(host_data_in),
      .host_data_out(host_data_out), .host_data_oe(host_data_oe), .chip_select_n(cs_n),
      .mem_reg_select(msel), .high_byte_enable_n(hbe_n), .low_byte_enable_n(lbe_n),
      .read_strobe_n(rd_n), .low_write_strobe_n(wr_n), .bus_start_n(bs_n),
      .hold_off_out(hold_off_out), .hold_off_oe(hold_off_oe), .buf_req(buf_req),
      .buf_write(buf_write), .buf_addr(buf_addr), .buf_wdata(buf_wdata),
      .buf_byte_en(buf_byte_en), .buf_ack(buf_ack), .buf_rdata(buf_rdata),
      .cfg_out(cfg_out), .regs_locked(regs_locked));

   pcp_card_host_model pcp_card_host_model_i (.clk(clk), .wait_high(wh),
      .hold_off_out(hold_off_out), .hold_off_oe(hold_off_oe), .host_data_oe(host_data_oe),
      .host_data_out(host_data_out), .host_address_in(addr), .host_data_in(host_data_in),
      .chip_select_n(cs_n), .mem_reg_select(msel), .high_byte_enable_n(hbe_n),
      .low_byte_enable_n(lbe_n), .read_strobe_n(rd_n), .low_write_strobe_n(wr_n),
      .bus_start_n(bs_n));

   // buffer arbiter stand-in: stalls three cycles, as refresh contention would
   always @(negedge clk) begin
      buf_ack <= 1'b0;
      buf_rdata <= ~buf_rdata;
      if (buf_req && !buf_ack) begin
         stall <= stall + 1;
         if (stall == 3) begin
            stall <= 0;
            buf_ack <= 1'b1;
            last_addr <= buf_addr;
            buf_rdata <= bmem[buf_addr[3:0]];
            if (buf_write && buf_byte_en[0]) bmem[buf_addr[3:0]][7:0] <= buf_wdata[7:0];
            if (buf_write && buf_byte_en[1]) bmem[buf_addr[3:0]][15:8] <= buf_wdata[15:8];
         end
      end
   end

   task automatic print_verdict;
      if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   // hang guard, well above the several hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         print_verdict();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic rst(input logic [15:0] s, input logic w);
      strap = s;
      wh = w;
      sys_rst = 1'b1; // card reset as the board inverter presents it
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      repeat (3) @(negedge clk);
   endtask : rst

   task automatic wr(input logic m, input logic [20:0] a, input logic [1:0] be, input logic [15:0] v);
      pcp_card_host_model_i.xfer(1'b0, m, a, be, v, d, ok);
      chk("write done", 16'h1, {15'h0, ok});
   endtask : wr

   task automatic rdc(input logic m, input logic [20:0] a, input logic [1:0] be, input logic [15:0] e);
      pcp_card_host_model_i.xfer(1'b1, m, a, be, 16'h0000, d, ok);
      chk("read done", 16'h1, {15'h0, ok});
      chk("read data", e, d);
   endtask : rdc

   // main sequence: little endian card setup, then big endian, then a foreign interface
   initial begin
      rst(16'h001e, 1'b0);
      chk("cfg", 16'h000f, {8'h00, cfg_out});
      chk("locked", 16'h1, {15'h0, regs_locked});
      // deselect briefly: without the drive strap the wait pin must float
      pcp_card_host_model_i.chip_select_n = 1'b1;
      repeat (6) @(negedge clk);
      chk("hold float", 16'h0, {15'h0, hold_off_oe});
      pcp_card_host_model_i.chip_select_n = 1'b0;
      repeat (6) @(negedge clk);
      chk("hold driven", 16'h1, {15'h0, hold_off_oe});
      rdc(1'b0, 21'h000000, 2'b00, {8'h80, ID});
      wr(1'b0, 21'h000004, 2'b00, 16'hbeef);
      rdc(1'b0, 21'h000004, 2'b00, 16'h0000);
      wr(1'b0, 21'h000001, 2'b01, 16'h00ff);
      chk("locked", 16'h0, {15'h0, regs_locked});
      rdc(1'b0, 21'h000000, 2'b00, {8'h00, ID});
      wr(1'b0, 21'h1000c4, 2'b00, 16'h1234);
      rdc(1'b0, 21'h000004, 2'b00, 16'h1234);
      wr(1'b0, 21'h000004, 2'b10, 16'hffab);
      rdc(1'b0, 21'h000044, 2'b00, 16'h12ab);
      wr(1'b0, 21'h00002e, 2'b00, 16'ha5a5);
      rdc(1'b0, 21'h00002e, 2'b00, 16'h00a5);
      wr(1'b1, 21'h000010, 2'b00, 16'hcafe);
      chk("buf addr", 16'h0008, last_addr[15:0]);
      wr(1'b1, 21'h000011, 2'b01, 16'h5500);
      rdc(1'b1, 21'h000010, 2'b00, 16'h55fe);
      rst(16'h982e, 1'b1);
      chk("cfg", 16'h00f7, {8'h00, cfg_out});
      chk("hold oe", 16'h1, {15'h0, hold_off_oe});
      chk("hold idle", 16'h0, {15'h0, hold_off_out});
      rdc(1'b0, 21'h000000, 2'b00, {ID, 8'h80});
      rst(16'h001c, 1'b0);
      pcp_card_host_model_i.xfer(1'b1, 1'b0, 21'h000000, 2'b00, 16'h0000, d, ok);
      chk("no answer", 16'h0, {15'h0, ok});
      print_verdict();
   end
endmodule : pcp_host_port_tb
